/* File: rtl/srm_top.sv */
// Status reporting block: two status groups, standard event register,
// error queue, status byte and service request, driven by a command port.
// Assumes commands, condition bits and instrument handshakes come from
// logic on sys_clk_i; one command is taken per cycle when ready is high.
//
// Overview of operation
// - Condition registers follow live instrument states.
// - Event bits latch on qualified change, no counting.
// - Event bits clear only by query, clear-status or preset.
// - Enable masks gate events into group summary.
// - Preset clears events, loads masks and filters.
// - Filters select rising or falling condition edges.
// - Clear-status clears events, errors, pending completion.
// - Standard-event mask, 0-255, gates summary bit 5.
// - Standard-event query returns bits then clears them.
// - Completion command sets bit 0 after prior work.
// - Completion query answers 1, holds later commands.
// - Service mask on status byte drives request.
// - Status query matches poll, keeps bit 6.
// - Bit 4 shows output buffer holds data.
// - Clearing group events clears its summary bit.
// - Status byte bits 2,3,7 mapped; 0,1 zero.
// - Wait command holds commands until current finishes.
// - Self-test answers zero or failed-test count.
// - Reset command pulses the settings reset output for one cycle.
// - Error queue of 30, oldest first, overflow marker.
`timescale 1ns/1ps
`default_nettype none
`include "srm_map.svh"

module srm_top
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire srm_pkg::srm_cmd_type cmd_op_i,
	input wire logic cmd_grp_i,
	input wire logic [15:0] cmd_data_i,
	input wire logic [15:0] ques_cond_i,
	input wire logic [15:0] oper_cond_i,
	input wire logic [7:0] std_event_set_i,
	input wire logic err_push_i,
	input wire logic [15:0] err_code_i,
	input wire logic exec_busy_i,
	input wire logic msg_avail_i,
	input wire logic selftest_done_i,
	input wire logic [15:0] selftest_fails_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [15:0] rsp_data_o,
	output logic [7:0] stb_o,
	output logic srq_o,
	output logic settings_reset_o,
	output logic selftest_run_o
);

	srm_pkg::srm_state_type state_q, state_d;
	logic ready_q, ready_d;
	logic rsp_valid_q, rsp_valid_d;
	logic [15:0] rsp_data_q, rsp_data_d;
	logic [7:0] stb_q, stb_d, sb_raw, sb_rise;
	logic rqs_q, rqs_d;
	logic [7:0] esr_q, esr_d, ese_q, ese_d, sre_q, sre_d;
	logic opc_pend_q, opc_pend_d, opc_set;
	logic rst_pulse_q, rst_pulse_d, run_q, run_d;
	logic taken, cls, preset, esr_clr;
	logic [1:0][15:0] grp_cond, grp_evt, grp_ena, grp_ptr, grp_ntr;
	logic [1:0] grp_sum, grp_sel, ena_wr, ptr_wr, ntr_wr, evt_clr;

	logic [15:0] errq_mem [0:29];
	logic [4:0] err_cnt_q, err_cnt_d, err_rd_q, err_rd_d, err_wr_q, err_wr_d;
	logic [4:0] cnt_base, rd_base, wr_base, cnt_mid;
	logic err_pop, err_we;
	logic [4:0] err_wa;
	logic [15:0] err_wd;

	function automatic logic [4:0] ptr_inc(input logic [4:0] p);
		ptr_inc = (p == `SRM_ERRQ_LAST) ? `SRM_ERRQ_PTR_ZERO : p + 5'h01;
	endfunction

	function automatic logic [4:0] ptr_dec(input logic [4:0] p);
		ptr_dec = (p == `SRM_ERRQ_PTR_ZERO) ? `SRM_ERRQ_LAST : p - 5'h01;
	endfunction

	assign taken = cmd_valid_i & ready_q;
	assign cls = taken & (cmd_op_i == srm_pkg::SRM_CMD_CLS);
	assign preset = taken & (cmd_op_i == srm_pkg::SRM_CMD_PRESET);
	assign esr_clr = cls | (taken & (cmd_op_i == srm_pkg::SRM_CMD_ESR_Q));
	assign grp_cond[`SRM_GRP_QUES] = ques_cond_i;
	assign grp_cond[`SRM_GRP_OPER] = oper_cond_i;

	always_comb
	begin
		grp_sel = 2'h0;
		grp_sel[cmd_grp_i] = taken;
		ena_wr = grp_sel & {2{cmd_op_i == srm_pkg::SRM_CMD_GRP_ENA_W}};
		ptr_wr = grp_sel & {2{cmd_op_i == srm_pkg::SRM_CMD_GRP_PTR_W}};
		ntr_wr = grp_sel & {2{cmd_op_i == srm_pkg::SRM_CMD_GRP_NTR_W}};
		// Group event query clears that group; clear-status and preset all
		evt_clr = (grp_sel & {2{cmd_op_i == srm_pkg::SRM_CMD_GRP_EVT_Q}})
			| {2{cls | preset}};
	end

	srm_group u_ques
	(
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.cond_i(grp_cond[`SRM_GRP_QUES]),
		.wdata_i(cmd_data_i),
		.ena_wr_i(ena_wr[`SRM_GRP_QUES]),
		.ptr_wr_i(ptr_wr[`SRM_GRP_QUES]),
		.ntr_wr_i(ntr_wr[`SRM_GRP_QUES]),
		.evt_clr_i(evt_clr[`SRM_GRP_QUES]),
		.preset_i(preset),
		.event_o(grp_evt[`SRM_GRP_QUES]),
		.ena_o(grp_ena[`SRM_GRP_QUES]),
		.ptr_o(grp_ptr[`SRM_GRP_QUES]),
		.ntr_o(grp_ntr[`SRM_GRP_QUES]),
		.summary_o(grp_sum[`SRM_GRP_QUES])
	);

	srm_group u_oper
	(
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.cond_i(grp_cond[`SRM_GRP_OPER]),
		.wdata_i(cmd_data_i),
		.ena_wr_i(ena_wr[`SRM_GRP_OPER]),
		.ptr_wr_i(ptr_wr[`SRM_GRP_OPER]),
		.ntr_wr_i(ntr_wr[`SRM_GRP_OPER]),
		.evt_clr_i(evt_clr[`SRM_GRP_OPER]),
		.preset_i(preset),
		.event_o(grp_evt[`SRM_GRP_OPER]),
		.ena_o(grp_ena[`SRM_GRP_OPER]),
		.ptr_o(grp_ptr[`SRM_GRP_OPER]),
		.ntr_o(grp_ntr[`SRM_GRP_OPER]),
		.summary_o(grp_sum[`SRM_GRP_OPER])
	);

	// Error queue bookkeeping
	always_comb
	begin
		err_pop = taken & (cmd_op_i == srm_pkg::SRM_CMD_ERR_Q)
			& (err_cnt_q != `SRM_ERRQ_PTR_ZERO) & ~cls;
		cnt_base = cls ? `SRM_ERRQ_PTR_ZERO : err_cnt_q;
		rd_base = cls ? `SRM_ERRQ_PTR_ZERO : err_rd_q;
		wr_base = cls ? `SRM_ERRQ_PTR_ZERO : err_wr_q;
		cnt_mid = err_pop ? cnt_base - 5'h01 : cnt_base;
		err_rd_d = err_pop ? ptr_inc(rd_base) : rd_base;
		err_cnt_d = cnt_mid;
		err_wr_d = wr_base;
		err_we = 1'b0;
		err_wa = wr_base;
		err_wd = err_code_i;
		if (err_push_i)
		begin
			err_we = 1'b1;
			if (cnt_mid != `SRM_ERRQ_DEPTH)
			begin
				err_wr_d = ptr_inc(wr_base);
				err_cnt_d = cnt_mid + 5'h01;
			end
			else
			begin
				// Full: newest slot turns into the overflow marker
				err_wa = ptr_dec(wr_base);
				err_wd = `SRM_ERR_OVERFLOW;
			end
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (err_we)
			errq_mem[err_wa] <= err_wd;
	end

	// Status byte, service request and standard events
	always_comb
	begin
		opc_set = opc_pend_q & ~exec_busy_i;
		opc_pend_d = opc_pend_q & ~opc_set;
		if (taken & (cmd_op_i == srm_pkg::SRM_CMD_OPC))
			opc_pend_d = 1'b1;
		if (cls)
			opc_pend_d = 1'b0;
		esr_d = (esr_clr ? `SRM_BYTE_CLEAR : esr_q) | std_event_set_i;
		esr_d[`SRM_ESR_OPC_BIT] = esr_d[`SRM_ESR_OPC_BIT] | opc_set;
		ese_d = ese_q;
		if (taken & (cmd_op_i == srm_pkg::SRM_CMD_ESE_W))
			ese_d = cmd_data_i[7:0];
		sre_d = sre_q;
		if (taken & (cmd_op_i == srm_pkg::SRM_CMD_SRE_W))
			sre_d = cmd_data_i[7:0] & `SRM_SRE_MASK;
		sb_raw = `SRM_BYTE_CLEAR;
		sb_raw[`SRM_STB_ERR_BIT] = err_cnt_q != `SRM_ERRQ_PTR_ZERO;
		// Group summaries follow live events, so a clear drops them
		sb_raw[`SRM_STB_QUES_BIT] = grp_sum[`SRM_GRP_QUES];
		sb_raw[`SRM_STB_OPER_BIT] = grp_sum[`SRM_GRP_OPER];
		// Own pending answer counts as buffered output as well
		sb_raw[`SRM_STB_MAV_BIT] = msg_avail_i | rsp_valid_q;
		sb_raw[`SRM_STB_ESB_BIT] = |(esr_q & ese_q);
		sb_rise = sb_raw & ~stb_q & sre_q;
		// Only a serial poll clears the request; a new rise still wins
		rqs_d = (rqs_q & ~(taken & (cmd_op_i == srm_pkg::SRM_CMD_SPOLL)))
			| (|sb_rise);
		stb_d = sb_raw;
		stb_d[`SRM_STB_RQS_BIT] = rqs_d;
	end

	// Command sequencing and answers
	always_comb
	begin
		state_d = state_q;
		rsp_valid_d = 1'b0;
		rsp_data_d = `SRM_REG_CLEAR;
		rst_pulse_d = 1'b0;
		run_d = 1'b0;
		case (state_q)
			srm_pkg::SRM_ST_IDLE:
			begin
				if (taken)
				begin
					rsp_valid_d = 1'b1;
					case (cmd_op_i)
						srm_pkg::SRM_CMD_ESE_Q: rsp_data_d = {8'h00, ese_q};
						srm_pkg::SRM_CMD_ESR_Q: rsp_data_d = {8'h00, esr_q};
						srm_pkg::SRM_CMD_SRE_Q: rsp_data_d = {8'h00, sre_q};
						srm_pkg::SRM_CMD_STB_Q: rsp_data_d = {8'h00, stb_q};
						srm_pkg::SRM_CMD_SPOLL: rsp_data_d = {8'h00, stb_q};
						srm_pkg::SRM_CMD_ERR_Q:
							rsp_data_d = (err_cnt_q != `SRM_ERRQ_PTR_ZERO)
								? errq_mem[err_rd_q] : `SRM_ERR_NONE;
						srm_pkg::SRM_CMD_GRP_EVT_Q: rsp_data_d = grp_evt[cmd_grp_i];
						srm_pkg::SRM_CMD_GRP_COND_Q:
							rsp_data_d = grp_cond[cmd_grp_i];
						srm_pkg::SRM_CMD_GRP_ENA_Q: rsp_data_d = grp_ena[cmd_grp_i];
						srm_pkg::SRM_CMD_GRP_PTR_Q: rsp_data_d = grp_ptr[cmd_grp_i];
						srm_pkg::SRM_CMD_GRP_NTR_Q: rsp_data_d = grp_ntr[cmd_grp_i];
						srm_pkg::SRM_CMD_OPC_Q:
						begin
							rsp_valid_d = 1'b0;
							state_d = srm_pkg::SRM_ST_OPCQ;
						end
						srm_pkg::SRM_CMD_WAI:
						begin
							rsp_valid_d = 1'b0;
							state_d = srm_pkg::SRM_ST_WAI;
						end
						srm_pkg::SRM_CMD_TST_Q:
						begin
							rsp_valid_d = 1'b0;
							run_d = 1'b1;
							state_d = srm_pkg::SRM_ST_TEST;
						end
						srm_pkg::SRM_CMD_RST:
						begin
							rsp_valid_d = 1'b0;
							rst_pulse_d = 1'b1;
						end
						default: rsp_valid_d = 1'b0;
					endcase
				end
			end
			srm_pkg::SRM_ST_OPCQ:
			begin
				if (!exec_busy_i)
				begin
					rsp_valid_d = 1'b1;
					rsp_data_d = `SRM_OPCQ_ANSWER;
					state_d = srm_pkg::SRM_ST_IDLE;
				end
			end
			srm_pkg::SRM_ST_WAI:
			begin
				if (!exec_busy_i)
					state_d = srm_pkg::SRM_ST_IDLE;
			end
			srm_pkg::SRM_ST_TEST:
			begin
				if (selftest_done_i)
				begin
					rsp_valid_d = 1'b1;
					rsp_data_d = selftest_fails_i;
					state_d = srm_pkg::SRM_ST_IDLE;
				end
			end
			default: state_d = srm_pkg::SRM_ST_IDLE;
		endcase
		ready_d = state_d == srm_pkg::SRM_ST_IDLE;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state_q <= srm_pkg::SRM_ST_IDLE;
			ready_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= `SRM_REG_CLEAR;
			rst_pulse_q <= 1'b0;
			run_q <= 1'b0;
			stb_q <= `SRM_BYTE_CLEAR;
			rqs_q <= 1'b0;
			esr_q <= `SRM_BYTE_CLEAR;
			ese_q <= `SRM_BYTE_CLEAR;
			sre_q <= `SRM_BYTE_CLEAR;
			opc_pend_q <= 1'b0;
			err_cnt_q <= `SRM_ERRQ_PTR_ZERO;
			err_rd_q <= `SRM_ERRQ_PTR_ZERO;
			err_wr_q <= `SRM_ERRQ_PTR_ZERO;
		end
		else
		begin
			state_q <= state_d;
			ready_q <= ready_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q <= rsp_data_d;
			rst_pulse_q <= rst_pulse_d;
			run_q <= run_d;
			stb_q <= stb_d;
			rqs_q <= rqs_d;
			esr_q <= esr_d;
			ese_q <= ese_d;
			sre_q <= sre_d;
			opc_pend_q <= opc_pend_d;
			err_cnt_q <= err_cnt_d;
			err_rd_q <= err_rd_d;
			err_wr_q <= err_wr_d;
		end
	end

	assign cmd_ready_o = ready_q;
	assign rsp_valid_o = rsp_valid_q;
	assign rsp_data_o = rsp_data_q;
	assign stb_o = stb_q;
	assign srq_o = rqs_q;
	assign settings_reset_o = rst_pulse_q;
	assign selftest_run_o = run_q;

endmodule

`default_nettype wire

/* File: rtl/srm_map.svh */
// Named constants of the status reporting block.
// Included by bare name; holds definitions only.
`ifndef SRM_MAP_SVH
`define SRM_MAP_SVH

`define SRM_ENA_PRESET 16'h0000
`define SRM_PTR_PRESET 16'hffff
`define SRM_NTR_PRESET 16'h0000
`define SRM_REG_CLEAR 16'h0000
`define SRM_BYTE_CLEAR 8'h00
`define SRM_STB_ERR_BIT 2
`define SRM_STB_QUES_BIT 3
`define SRM_STB_MAV_BIT 4
`define SRM_STB_ESB_BIT 5
`define SRM_STB_RQS_BIT 6
`define SRM_STB_OPER_BIT 7
`define SRM_SRE_MASK 8'hbc
`define SRM_ESR_OPC_BIT 0
`define SRM_ERRQ_DEPTH 5'h1e
`define SRM_ERRQ_LAST 5'h1d
`define SRM_ERRQ_PTR_ZERO 5'h00
`define SRM_ERR_OVERFLOW 16'hfea2
`define SRM_ERR_NONE 16'h0000
`define SRM_OPCQ_ANSWER 16'h0001
`define SRM_GRP_QUES 1'b0
`define SRM_GRP_OPER 1'b1

`endif

/* File: rtl/srm_pkg.sv */
// Types shared by the status reporting block.
// No assumptions beyond a SystemVerilog compiler.
package srm_pkg;

	typedef enum logic [4:0] {
		SRM_CMD_CLS,
		SRM_CMD_ESE_W,
		SRM_CMD_ESE_Q,
		SRM_CMD_ESR_Q,
		SRM_CMD_OPC,
		SRM_CMD_OPC_Q,
		SRM_CMD_RST,
		SRM_CMD_SRE_W,
		SRM_CMD_SRE_Q,
		SRM_CMD_STB_Q,
		SRM_CMD_SPOLL,
		SRM_CMD_TST_Q,
		SRM_CMD_WAI,
		SRM_CMD_PRESET,
		SRM_CMD_ERR_Q,
		SRM_CMD_GRP_EVT_Q,
		SRM_CMD_GRP_COND_Q,
		SRM_CMD_GRP_ENA_W,
		SRM_CMD_GRP_ENA_Q,
		SRM_CMD_GRP_PTR_W,
		SRM_CMD_GRP_PTR_Q,
		SRM_CMD_GRP_NTR_W,
		SRM_CMD_GRP_NTR_Q
	} srm_cmd_type;

	typedef enum logic [1:0] {
		SRM_ST_IDLE,
		SRM_ST_OPCQ,
		SRM_ST_WAI,
		SRM_ST_TEST
	} srm_state_type;

endpackage

/* File: rtl/srm_group.sv */
// One status register group: condition, transition filters, event, enable.
// Condition bits come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "srm_map.svh"

module srm_group
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [15:0] cond_i,
	input wire logic [15:0] wdata_i,
	input wire logic ena_wr_i,
	input wire logic ptr_wr_i,
	input wire logic ntr_wr_i,
	input wire logic evt_clr_i,
	input wire logic preset_i,
	output logic [15:0] event_o,
	output logic [15:0] ena_o,
	output logic [15:0] ptr_o,
	output logic [15:0] ntr_o,
	output logic summary_o
);

	logic [15:0] prev_q, prev_d;
	logic [15:0] edge_q, edge_d;
	logic [15:0] evt_q, evt_d;
	logic [15:0] ena_q, ena_d;
	logic [15:0] ptr_q, ptr_d;
	logic [15:0] ntr_q, ntr_d;

	always_comb
	begin
		prev_d = cond_i;
		// Edge found now is latched into the event one cycle later
		edge_d = (cond_i & ~prev_q & ptr_q) | (~cond_i & prev_q & ntr_q);
		// A set bit just stays one; arriving edge beats a clear
		evt_d = (evt_clr_i ? `SRM_REG_CLEAR : evt_q) | edge_q;
		ena_d = ena_q;
		ptr_d = ptr_q;
		ntr_d = ntr_q;
		if (preset_i)
		begin
			ena_d = `SRM_ENA_PRESET;
			ptr_d = `SRM_PTR_PRESET;
			ntr_d = `SRM_NTR_PRESET;
		end
		else
		begin
			if (ena_wr_i)
				ena_d = wdata_i;
			if (ptr_wr_i)
				ptr_d = wdata_i;
			if (ntr_wr_i)
				ntr_d = wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			prev_q <= `SRM_REG_CLEAR;
			edge_q <= `SRM_REG_CLEAR;
			evt_q <= `SRM_REG_CLEAR;
			ena_q <= `SRM_ENA_PRESET;
			ptr_q <= `SRM_PTR_PRESET;
			ntr_q <= `SRM_NTR_PRESET;
		end
		else
		begin
			prev_q <= prev_d;
			edge_q <= edge_d;
			evt_q <= evt_d;
			ena_q <= ena_d;
			ptr_q <= ptr_d;
			ntr_q <= ntr_d;
		end
	end

	assign event_o = evt_q;
	assign ena_o = ena_q;
	assign ptr_o = ptr_q;
	assign ntr_o = ntr_q;
	assign summary_o = |(evt_q & ena_q);

endmodule

`default_nettype wire

/* File: tb/srm_monitor.sv */
// Checker for the status reporting block, bound to its top module.
// Sees top-level ports only; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module srm_monitor
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic cmd_valid_i,
	input wire srm_pkg::srm_cmd_type cmd_op_i,
	input wire logic err_push_i,
	input wire logic exec_busy_i,
	input wire logic msg_avail_i,
	input wire logic cmd_ready_o,
	input wire logic rsp_valid_o,
	input wire logic [15:0] rsp_data_o,
	input wire logic [7:0] stb_o,
	input wire logic settings_reset_o,
	input wire logic selftest_run_o
);
	logic tk;
	assign tk = cmd_valid_i & cmd_ready_o;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	a_stb_unused: assert property (stb_o[1:0] == 2'b00)
		else $error("status byte low bits set");
	a_mav_shown: assert property (msg_avail_i |=> stb_o[4])
		else $error("message bit missing");
	a_err_shown: assert property (err_push_i && !cmd_valid_i
		##1 !cmd_valid_i |=> stb_o[2]) else $error("error bit missing");
	a_reset_pulse: assert property (tk && cmd_op_i == srm_pkg::SRM_CMD_RST
		|=> settings_reset_o) else $error("settings reset missing");
	a_test_start: assert property (tk && cmd_op_i == srm_pkg::SRM_CMD_TST_Q
		|=> selftest_run_o) else $error("self test not started");
	a_wait_block: assert property (tk && cmd_op_i == srm_pkg::SRM_CMD_WAI
		|=> !cmd_ready_o) else $error("wait did not hold commands");
	a_opcq_answer: assert property (tk && cmd_op_i == srm_pkg::SRM_CMD_OPC_Q
		##1 !exec_busy_i |=> rsp_valid_o && rsp_data_o == 16'h0001)
		else $error("completion answer wrong");
	a_stb_keep: assert property (tk && cmd_op_i == srm_pkg::SRM_CMD_STB_Q
		&& stb_o[6] |=> stb_o[6]) else $error("status query cleared bit 6");
	a_esr_answer: assert property (tk && cmd_op_i == srm_pkg::SRM_CMD_ESR_Q
		|=> rsp_valid_o) else $error("event query unanswered");
endmodule
`default_nettype wire

/* File: tb/srm_host.sv */
// Host controller model: issues one command at a time, collects answers.
// Assumes ready and answer outputs of the block are registered.
`timescale 1ns/1ps
`default_nettype none
module srm_host
(
	input wire logic sys_clk_i,
	input wire logic cmd_ready_i,
	input wire logic rsp_valid_i,
	input wire logic [15:0] rsp_data_i,
	output logic cmd_valid_o,
	output var srm_pkg::srm_cmd_type cmd_op_o,
	output logic cmd_grp_o,
	output logic [15:0] cmd_data_o
);
	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_op_o = srm_pkg::SRM_CMD_CLS;
		cmd_grp_o = 1'b0;
		cmd_data_o = 16'h0000;
	end
	task automatic cmd(input srm_pkg::srm_cmd_type op, input logic grp,
		input logic [15:0] data, input logic query, output logic [15:0] rsp);
		int n;
		n = 0;
		rsp = 16'hxxxx;
		cmd_valid_o <= 1'b1;
		cmd_op_o <= op;
		cmd_grp_o <= grp;
		cmd_data_o <= data;
		do
			@(posedge sys_clk_i);
		while (cmd_ready_i !== 1'b1 && ++n < 200);
		cmd_valid_o <= 1'b0;
		// Stale data is not left on the lines
		cmd_data_o <= ~data;
		@(posedge sys_clk_i);
		while (query && rsp_valid_i !== 1'b1 && ++n < 400)
			@(posedge sys_clk_i);
		if (query && rsp_valid_i === 1'b1)
			rsp = rsp_data_i;
	endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the status reporting block with a host model.
// Drives instrument inputs at rising edges; checker bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ep = 1'b0, busy = 1'b0, mav = 1'b0, sd = 1'b0;
	logic cv, grp, rdy, rv, srq;
	logic [7:0] ses = 8'h00;
	logic [7:0] stb, v, e;
	logic [15:0] qc = 16'h0000, oc = 16'h0000, ec = 16'h0000, sf = 16'h0000;
	logic [15:0] cd, rd, r, evt, ena, ntr, prev, cur;
	logic [15:0] codes [31];
	srm_pkg::srm_cmd_type op;
	int seed = 20;
	int mismatches = 0;
	int samples_checked = 0;
	always #2 clk = ~clk;
	srm_top uut (.sys_clk_i(clk), .rst_i(rst), .cmd_valid_i(cv), .cmd_op_i(op),
		.cmd_grp_i(grp), .cmd_data_i(cd), .ques_cond_i(qc), .oper_cond_i(oc),
		.std_event_set_i(ses), .err_push_i(ep), .err_code_i(ec),
		.exec_busy_i(busy), .msg_avail_i(mav), .selftest_done_i(sd),
		.selftest_fails_i(sf), .cmd_ready_o(rdy), .rsp_valid_o(rv),
		.rsp_data_o(rd), .stb_o(stb), .srq_o(srq), .settings_reset_o(),
		.selftest_run_o());
	srm_host host (.sys_clk_i(clk), .cmd_ready_i(rdy), .rsp_valid_i(rv),
		.rsp_data_i(rd), .cmd_valid_o(cv), .cmd_op_o(op), .cmd_grp_o(grp),
		.cmd_data_o(cd));
	function automatic logic [15:0] exp_evt(input logic [15:0] p, c, n);
		return (~p & c) | (p & ~c & n);
	endfunction
	function automatic logic [15:0] exp_err(input int i);
		return i < 29 ? codes[i] : (i == 29 ? 16'hfea2 : 16'h0000);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string s, input logic [15:0] x, y);
		samples_checked++;
		if (y !== x)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", s, x, y);
		end
	endtask
	task automatic qx(input srm_pkg::srm_cmd_type o, input logic g,
		input logic [15:0] x);
		host.cmd(o, g, 16'h0000, 1'b1, r);
		chk(o.name(), x, r);
	endtask
	task automatic w(input srm_pkg::srm_cmd_type o, input logic g,
		input logic [15:0] d);
		logic [15:0] t;
		host.cmd(o, g, d, 1'b0, t);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		cyc(5);
		rst <= 1'b0;
		cyc(1);
		chk("stb", 16'h0000, 16'(stb));
		for (int g = 0; g < 2; g++)
		begin
			ena = 16'($random(seed));
			ntr = 16'($random(seed));
			prev = 16'h0000;
			w(srm_pkg::SRM_CMD_GRP_ENA_W, g[0], ena);
			w(srm_pkg::SRM_CMD_GRP_NTR_W, g[0], ntr);
			repeat (2)
			begin
				cur = 16'($random(seed));
				{oc, qc} <= g ? {cur, qc} : {oc, cur};
				cyc(6);
				evt = exp_evt(prev, cur, ntr);
				chk("summary", 16'(|(evt & ena)), 16'(stb[3 + 4 * g]));
				qx(srm_pkg::SRM_CMD_GRP_COND_Q, g[0], cur);
				qx(srm_pkg::SRM_CMD_GRP_EVT_Q, g[0], evt);
				qx(srm_pkg::SRM_CMD_GRP_EVT_Q, g[0], 16'h0000);
				chk("summary", 16'h0000, 16'(stb[3 + 4 * g]));
				prev = cur;
			end
		end
		w(srm_pkg::SRM_CMD_GRP_PTR_W, 1'b0, 16'h00f0);
		w(srm_pkg::SRM_CMD_CLS, 1'b0, 16'h0000);
		qx(srm_pkg::SRM_CMD_GRP_ENA_Q, 1'b1, ena);
		qx(srm_pkg::SRM_CMD_GRP_PTR_Q, 1'b0, 16'h00f0);
		w(srm_pkg::SRM_CMD_PRESET, 1'b0, 16'h0000);
		for (int g = 0; g < 2; g++)
		begin
			qx(srm_pkg::SRM_CMD_GRP_ENA_Q, g[0], 16'h0000);
			qx(srm_pkg::SRM_CMD_GRP_PTR_Q, g[0], 16'hffff);
			qx(srm_pkg::SRM_CMD_GRP_NTR_Q, g[0], 16'h0000);
		end
		// Narrow rising filter, no falling filter: only masked rises latch
		w(srm_pkg::SRM_CMD_GRP_PTR_W, 1'b0, 16'h00f0);
		cur = ~qc;
		qc <= cur;
		cyc(4);
		qx(srm_pkg::SRM_CMD_GRP_EVT_Q, 1'b0, cur & 16'h00f0);
		$display("test groups finished");
		v = 8'($random(seed));
		e = 8'($random(seed));
		w(srm_pkg::SRM_CMD_ESE_W, 1'b0, 16'(e));
		ses <= v;
		cyc(1);
		ses <= 8'h00;
		cyc(3);
		chk("stb5", 16'(|(v & e)), 16'(stb[5]));
		qx(srm_pkg::SRM_CMD_ESE_Q, 1'b0, 16'(e));
		qx(srm_pkg::SRM_CMD_ESR_Q, 1'b0, 16'(v));
		qx(srm_pkg::SRM_CMD_ESR_Q, 1'b0, 16'h0000);
		busy <= 1'b1;
		w(srm_pkg::SRM_CMD_OPC, 1'b0, 16'h0000);
		cyc(4);
		qx(srm_pkg::SRM_CMD_ESR_Q, 1'b0, 16'h0000);
		busy <= 1'b0;
		cyc(3);
		qx(srm_pkg::SRM_CMD_ESR_Q, 1'b0, 16'h0001);
		busy <= 1'b1;
		w(srm_pkg::SRM_CMD_OPC, 1'b0, 16'h0000);
		w(srm_pkg::SRM_CMD_CLS, 1'b0, 16'h0000);
		busy <= 1'b0;
		cyc(3);
		qx(srm_pkg::SRM_CMD_ESR_Q, 1'b0, 16'h0000);
		qx(srm_pkg::SRM_CMD_OPC_Q, 1'b0, 16'h0001);
		busy <= 1'b1;
		fork
			qx(srm_pkg::SRM_CMD_OPC_Q, 1'b0, 16'h0001);
			begin
				cyc(6);
				chk("ready", 16'h0000, 16'(rdy));
				busy <= 1'b0;
			end
		join
		$display("test standard events finished");
		w(srm_pkg::SRM_CMD_ESE_W, 1'b0, 16'h00ff);
		// Bits 6 and 0 cannot be enabled; only bit 5 stays
		w(srm_pkg::SRM_CMD_SRE_W, 1'b0, 16'h0061);
		qx(srm_pkg::SRM_CMD_SRE_Q, 1'b0, 16'h0020);
		ses <= 8'h04;
		cyc(1);
		ses <= 8'h00;
		cyc(4);
		chk("srq", 16'h0001, 16'(srq));
		host.cmd(srm_pkg::SRM_CMD_STB_Q, 1'b0, 16'h0000, 1'b1, r);
		chk("stb query", 16'h0001, 16'(r[6]));
		chk("stb6", 16'h0001, 16'(stb[6]));
		host.cmd(srm_pkg::SRM_CMD_SPOLL, 1'b0, 16'h0000, 1'b1, r);
		chk("poll", 16'h0001, 16'(r[6]));
		cyc(1);
		chk("stb6", 16'h0000, 16'(stb[6]));
		qx(srm_pkg::SRM_CMD_ESR_Q, 1'b0, 16'h0004);
		ep <= 1'b1;
		for (int i = 0; i < 31; i++)
		begin
			codes[i] = 16'($random(seed));
			ec <= codes[i];
			cyc(1);
		end
		ep <= 1'b0;
		cyc(3);
		chk("stb2", 16'h0001, 16'(stb[2]));
		for (int i = 0; i < 31; i++)
			qx(srm_pkg::SRM_CMD_ERR_Q, 1'b0, exp_err(i));
		cyc(2);
		chk("stb2", 16'h0000, 16'(stb[2]));
		ep <= 1'b1;
		cyc(1);
		ep <= 1'b0;
		w(srm_pkg::SRM_CMD_CLS, 1'b0, 16'h0000);
		qx(srm_pkg::SRM_CMD_ERR_Q, 1'b0, 16'h0000);
		mav <= 1'b1;
		cyc(2);
		chk("stb4", 16'h0001, 16'(stb[4]));
		mav <= 1'b0;
		cyc(2);
		chk("stb4", 16'h0000, 16'(stb[4]));
		$display("test status byte finished");
		for (int k = 0; k < 2; k++)
		begin
			fork
				host.cmd(srm_pkg::SRM_CMD_TST_Q, 1'b0, 16'h0000, 1'b1, r);
				begin
					cyc(4);
					sf <= k ? 16'($random(seed)) : 16'h0000;
					sd <= 1'b1;
					cyc(1);
					sd <= 1'b0;
				end
			join
			chk("self test", sf, r);
		end
		busy <= 1'b1;
		fork
			w(srm_pkg::SRM_CMD_WAI, 1'b0, 16'h0000);
			begin
				cyc(4);
				chk("ready", 16'h0000, 16'(rdy));
				busy <= 1'b0;
			end
		join
		w(srm_pkg::SRM_CMD_RST, 1'b0, 16'h0000);
		cyc(3);
		$display("test control finished");
		finish_test();
	end
	initial
	begin
		cyc(20000);
		mismatches++;
		finish_test();
	end
endmodule
bind srm_top srm_monitor mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .err_push_i(err_push_i),
	.exec_busy_i(exec_busy_i), .msg_avail_i(msg_avail_i),
	.cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
	.rsp_data_o(rsp_data_o), .stb_o(stb_o),
	.settings_reset_o(settings_reset_o), .selftest_run_o(selftest_run_o));
`default_nettype wire
